/* logic/sfsp_defines.vh */
// Constants for the serial flash status and protection block.
// Included by the block's design file and by its testbench; definitions only.
`ifndef SFSP_DEFINES_VH
`define SFSP_DEFINES_VH
`define SFSP_OP_WRITE_UNLOCK_CMD 8'h06
`define SFSP_OP_WRDI 8'h04
`define SFSP_OP_RDSR 8'h05
`define SFSP_OP_RDCR 8'h15
`define SFSP_OP_STATUS_WRITE_CMD 8'h01
`define SFSP_OP_WRCR 8'h11
`define SFSP_OP_PP 8'h02
`define SFSP_OP_PE 8'h81
`define SFSP_OP_SE 8'h20
`define SFSP_OP_BE 8'hD8
`define SFSP_OP_CE 8'h60
`define SFSP_OP_SUS_A 8'h75
`define SFSP_OP_SUS_B 8'hB0
`define SFSP_OP_RES_A 8'h7A
`define SFSP_OP_RES_B 8'h30
`define SFSP_OP_DPD 8'hB9
`define SFSP_OP_RDPD 8'hAB
`define SFSP_ST_BUSY 0
`define SFSP_ST_WEL 1
`define SFSP_ST_BP_LO 2
`define SFSP_ST_STATUS_GUARD_LO 7
`define SFSP_ST_STATUS_GUARD_HI 8
`define SFSP_ST_QE 9
`define SFSP_ST_PSUS 10
`define SFSP_ST_LB_LO 11
`define SFSP_ST_CMP 14
`define SFSP_ST_ESUS 15
`define SFSP_CR_DP 7
`define SFSP_ST_RESET 16'h0000
`define SFSP_CR_RESET 8'h00
`define SFSP_PAGE_256_MASK 9'h0FF
`define SFSP_PAGE_512_MASK 9'h1FF
`define SFSP_BUSY_CYCLES 16'h0040
`endif

/* logic/sfsp_top.v */
// Status and configuration logic with write protection of a serial flash.
// Assumes SPI mode 0/3 pins sampled on the 40 MHz system clock; array is outside.
`timescale 1ns/1ps
`include "sfsp_defines.vh"
module sfsp_top (
  input wire I_CLK_SYS,
  input wire I_RESET_N,
  input wire I_CS_N,
  input wire I_SCLK,
  input wire I_SI,
  input wire I_WP_N,
  input wire I_PAUSE_N,
  output reg O_SO,
  output reg O_SO_OE,
  output reg O_PINS_ARE_DATA,
  output reg O_PAUSE_ACTIVE,
  output reg O_BUSY,
  output reg O_ERASE_REQ,
  output reg O_PROG_REQ,
  output reg O_DUAL_PAGE_WIPE,
  output reg [23:0] O_OP_ADDR,
  output reg [23:0] O_OP_LEN,
  output reg [8:0] O_LOAD_OFFSET,
  output reg O_LOAD_STROBE,
  output reg [7:0] O_LOAD_DATA,
  output reg O_DEEP_SLEEP,
  output reg [15:0] O_STATUS,
  output reg [7:0] O_CONFIG
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CMD = 2'b01;
  localparam ST_ARGS = 2'b10;
  localparam ST_SKIP = 2'b11;

  reg rst_m, rst_s;
  wire rst_n = rst_s;
  reg [1:0] cs_q, sck_q, si_q, wp_q, ps_q;
  reg sck_prev, cs_prev;
  wire cs_n = cs_q[1];
  wire sck = sck_q[1];
  wire sck_rise = sck & ~sck_prev;
  wire sck_fall = ~sck & sck_prev;
  wire cs_end = cs_n & ~cs_prev;

  reg [1:0] state;
  reg [7:0] opcode;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg [5:0] byte_cnt;
  reg [23:0] addr;
  reg [15:0] new_status;
  reg [7:0] new_config;
  reg [15:0] status;
  reg [7:0] config_r;
  reg [15:0] busy_cnt;
  reg [15:0] rd_shift;
  reg [8:0] load_off;
  reg is_erase_run;

  // Protected range [lo, hi] from guard bits and complement; hi < lo means none
  function [47:0] prot_range;
    input [4:0] bp;
    input cmp;
    reg [23:0] sz;
    reg top;
    reg all;
    reg none;
    begin
      sz = 24'h000000;
      all = 1'b0;
      none = 1'b0;
      top = ~bp[3];
      if (bp[2:0] == 3'b000) begin
        none = 1'b1;
      end else if (bp[2:1] == 2'b11 || (!bp[4] && bp[2:0] == 3'b101)) begin
        all = 1'b1;
      end else if (!bp[4]) begin
        sz = 24'h010000 << (bp[2:0] - 3'd1);
      end else if (bp[2]) begin
        sz = 24'h008000;
      end else begin
        sz = 24'h001000 << (bp[1:0] - 2'd1);
      end
      if (cmp) begin
        top = ~top;
        sz = 24'h100000 - sz;
        if (none | all) begin
          none = ~none;
          all = ~all;
        end
      end
      if (none)
        prot_range = {24'h000001, 24'h000000};
      else if (all)
        prot_range = {24'h000000, 24'h0FFFFF};
      else if (top)
        prot_range = {24'h100000 - sz, 24'h0FFFFF};
      else
        prot_range = {24'h000000, sz - 24'h000001};
    end
  endfunction

  wire [47:0] pr = prot_range(status[6:2], status[`SFSP_ST_CMP]);
  wire [23:0] pr_lo = pr[47:24];
  wire [23:0] pr_hi = pr[23:0];
  wire bp_none = (status[4:2] == 3'b000);
  wire status_guard_lo = status[`SFSP_ST_STATUS_GUARD_LO];
  wire status_guard_hi = status[`SFSP_ST_STATUS_GUARD_HI];
  wire qe = status[`SFSP_ST_QE];
  wire wp_pin = qe ? 1'b1 : wp_q[1];
  wire sr_locked = status_guard_hi | (status_guard_lo & ~wp_pin);
  wire write_latch = status[`SFSP_ST_WEL];
  wire busy = status[`SFSP_ST_BUSY];

  function [23:0] op_span;
    input [7:0] op;
    input dp;
    begin
      case (op)
        `SFSP_OP_PE: op_span = dp ? 24'h000200 : 24'h000100;
        `SFSP_OP_SE: op_span = 24'h001000;
        `SFSP_OP_BE: op_span = 24'h010000;
        default: op_span = dp ? 24'h000200 : 24'h000100;
      endcase
    end
  endfunction

  wire dp = config_r[`SFSP_CR_DP];
  wire [23:0] span = op_span(opcode, dp);
  wire [23:0] base = addr & ~(span - 24'h000001);
  wire [23:0] last = base + span - 24'h000001;
  wire hits_prot = (pr_lo <= pr_hi) && !(last < pr_lo || base > pr_hi);
  wire [8:0] wrap_mask = dp ? `SFSP_PAGE_512_MASK : `SFSP_PAGE_256_MASK;

  function is_modify;
    input [7:0] op;
    begin
      is_modify = (op == `SFSP_OP_STATUS_WRITE_CMD) || (op == `SFSP_OP_WRCR) || (op == `SFSP_OP_PP) ||
        (op == `SFSP_OP_PE) || (op == `SFSP_OP_SE) || (op == `SFSP_OP_BE) ||
        (op == `SFSP_OP_CE);
    end
  endfunction

  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 2'b11;
      sck_q <= 2'b00;
      si_q <= 2'b00;
      wp_q <= 2'b11;
      ps_q <= 2'b11;
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_q <= {cs_q[0], I_CS_N};
      sck_q <= {sck_q[0], I_SCLK};
      si_q <= {si_q[0], I_SI};
      wp_q <= {wp_q[0], I_WP_N};
      ps_q <= {ps_q[0], I_PAUSE_N};
      sck_prev <= sck;
      cs_prev <= cs_n;
    end
  end

  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      // Power-up lands in standby; power cycle drops 10 guard mode
      state <= ST_IDLE;
      opcode <= 8'h00;
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
      byte_cnt <= 6'd0;
      addr <= 24'h000000;
      new_status <= 16'h0000;
      new_config <= 8'h00;
      status <= `SFSP_ST_RESET;
      config_r <= `SFSP_CR_RESET;
      busy_cnt <= 16'h0000;
      rd_shift <= 16'h0000;
      load_off <= 9'h000;
      is_erase_run <= 1'b0;
      O_SO <= 1'b0;
      O_SO_OE <= 1'b0;
      O_PINS_ARE_DATA <= 1'b0;
      O_PAUSE_ACTIVE <= 1'b0;
      O_BUSY <= 1'b0;
      O_ERASE_REQ <= 1'b0;
      O_PROG_REQ <= 1'b0;
      O_DUAL_PAGE_WIPE <= 1'b0;
      O_OP_ADDR <= 24'h000000;
      O_OP_LEN <= 24'h000000;
      O_LOAD_OFFSET <= 9'h000;
      O_LOAD_STROBE <= 1'b0;
      O_LOAD_DATA <= 8'h00;
      O_DEEP_SLEEP <= 1'b0;
      O_STATUS <= `SFSP_ST_RESET;
      O_CONFIG <= `SFSP_CR_RESET;
    end else begin
      O_ERASE_REQ <= 1'b0;
      O_PROG_REQ <= 1'b0;
      O_LOAD_STROBE <= 1'b0;
      // Quad mode hands guard and pause pins over as data lines
      O_PINS_ARE_DATA <= qe;
      O_PAUSE_ACTIVE <= ~qe & ~ps_q[1] & ~cs_n;
      // Countdown holds while suspended so resume finishes the remaining time
      if (busy_cnt != 16'h0000 && busy) begin
        busy_cnt <= busy_cnt - 16'h0001;
        if (busy_cnt == 16'h0001) begin
          status[`SFSP_ST_BUSY] <= 1'b0;
          status[`SFSP_ST_WEL] <= 1'b0;
        end
      end
      if (cs_n) begin
        O_SO_OE <= 1'b0;
        state <= ST_IDLE;
      end
      // A frame with no whole opcode never replays the previous command
      if (cs_end && state == ST_ARGS && !O_DEEP_SLEEP) begin
        // Only commands ending exactly on a byte boundary take effect
        if (bit_cnt != 3'd0) begin
          status[`SFSP_ST_WEL] <= 1'b0;
        end else if (is_modify(opcode) && (!write_latch || busy)) begin
          status[`SFSP_ST_WEL] <= 1'b0;
        end else begin
          case (opcode)
            `SFSP_OP_WRITE_UNLOCK_CMD: if (!busy) status[`SFSP_ST_WEL] <= 1'b1;
            `SFSP_OP_WRDI: if (!busy) status[`SFSP_ST_WEL] <= 1'b0;
            `SFSP_OP_STATUS_WRITE_CMD: begin
              if (sr_locked || byte_cnt == 6'd0) begin
                status[`SFSP_ST_WEL] <= 1'b0;
              end else begin
                // Region guard bits only reach here when unlocked
                status[6:2] <= new_status[6:2];
                status[`SFSP_ST_STATUS_GUARD_LO] <= new_status[`SFSP_ST_STATUS_GUARD_LO];
                if (byte_cnt > 6'd1) begin
                  status[`SFSP_ST_STATUS_GUARD_HI] <= new_status[`SFSP_ST_STATUS_GUARD_HI];
                  status[`SFSP_ST_QE] <= new_status[`SFSP_ST_QE];
                  status[13:11] <= status[13:11] | new_status[13:11];
                  status[`SFSP_ST_CMP] <= new_status[`SFSP_ST_CMP];
                end
                status[`SFSP_ST_BUSY] <= 1'b1;
                busy_cnt <= `SFSP_BUSY_CYCLES;
              end
            end
            `SFSP_OP_WRCR: begin
              if (byte_cnt == 6'd0) begin
                status[`SFSP_ST_WEL] <= 1'b0;
              end else begin
                config_r[`SFSP_CR_DP] <= new_config[`SFSP_CR_DP];
                status[`SFSP_ST_BUSY] <= 1'b1;
                busy_cnt <= `SFSP_BUSY_CYCLES;
              end
            end
            `SFSP_OP_PP, `SFSP_OP_PE, `SFSP_OP_SE, `SFSP_OP_BE: begin
              if (byte_cnt < 6'd3 || hits_prot) begin
                status[`SFSP_ST_WEL] <= 1'b0;
              end else begin
                O_OP_ADDR <= base;
                O_OP_LEN <= span;
                O_DUAL_PAGE_WIPE <= dp && opcode == `SFSP_OP_PE;
                O_PROG_REQ <= opcode == `SFSP_OP_PP;
                O_ERASE_REQ <= opcode != `SFSP_OP_PP;
                is_erase_run <= opcode != `SFSP_OP_PP;
                status[`SFSP_ST_BUSY] <= 1'b1;
                busy_cnt <= `SFSP_BUSY_CYCLES;
              end
            end
            `SFSP_OP_CE: begin
              if (!bp_none) begin
                status[`SFSP_ST_WEL] <= 1'b0;
              end else begin
                O_OP_ADDR <= 24'h000000;
                O_OP_LEN <= 24'h100000;
                O_ERASE_REQ <= 1'b1;
                is_erase_run <= 1'b1;
                status[`SFSP_ST_BUSY] <= 1'b1;
                busy_cnt <= `SFSP_BUSY_CYCLES;
              end
            end
            `SFSP_OP_SUS_A, `SFSP_OP_SUS_B: begin
              if (busy && busy_cnt != 16'h0000) begin
                if (is_erase_run)
                  status[`SFSP_ST_ESUS] <= 1'b1;
                else
                  status[`SFSP_ST_PSUS] <= 1'b1;
                status[`SFSP_ST_BUSY] <= 1'b0;
              end
            end
            `SFSP_OP_RES_A, `SFSP_OP_RES_B: begin
              if (status[`SFSP_ST_ESUS] | status[`SFSP_ST_PSUS])
                status[`SFSP_ST_BUSY] <= 1'b1;
              status[`SFSP_ST_ESUS] <= 1'b0;
              status[`SFSP_ST_PSUS] <= 1'b0;
            end
            `SFSP_OP_DPD: if (!busy) O_DEEP_SLEEP <= 1'b1;
            default: ;
          endcase
        end
      end else if (cs_end && O_DEEP_SLEEP && state == ST_ARGS && bit_cnt == 3'd0 &&
          opcode == `SFSP_OP_RDPD) begin
        O_DEEP_SLEEP <= 1'b0;
      end
      if (!cs_n && !O_PAUSE_ACTIVE) begin
        case (state)
          ST_IDLE: begin
            state <= ST_CMD;
            bit_cnt <= 3'd0;
            byte_cnt <= 6'd0;
            load_off <= 9'h000;
          end
          ST_CMD, ST_ARGS: begin
            if (sck_rise) begin
              shreg <= {shreg[6:0], si_q[1]};
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7) begin
                if (state == ST_CMD) begin
                  opcode <= {shreg[6:0], si_q[1]};
                  state <= ST_ARGS;
                  rd_shift <= status;
                  if ({shreg[6:0], si_q[1]} == `SFSP_OP_RDCR)
                    rd_shift <= {config_r, 8'h00};
                  // Deep sleep parks every other command
                  if (O_DEEP_SLEEP && {shreg[6:0], si_q[1]} != `SFSP_OP_RDPD)
                    state <= ST_SKIP;
                end else begin
                  if (byte_cnt != 6'h3F)
                    byte_cnt <= byte_cnt + 6'd1;
                  if (byte_cnt == 6'd0)
                    new_status[7:0] <= {shreg[6:0], si_q[1]};
                  if (byte_cnt == 6'd1)
                    new_status[15:8] <= {shreg[6:0], si_q[1]};
                  if (byte_cnt == 6'd0)
                    new_config <= {shreg[6:0], si_q[1]};
                  if (byte_cnt < 6'd3)
                    addr <= {addr[15:0], shreg[6:0], si_q[1]};
                  else if (opcode == `SFSP_OP_PP && write_latch && !busy) begin
                    // Load offset wraps at the selected page size
                    O_LOAD_OFFSET <= (load_off + {1'b0, addr[7:0]}) & wrap_mask;
                    O_LOAD_DATA <= {shreg[6:0], si_q[1]};
                    O_LOAD_STROBE <= 1'b1;
                    load_off <= load_off + 9'h001;
                  end
                end
              end
            end
            if (sck_fall && state == ST_ARGS &&
                (opcode == `SFSP_OP_RDSR || opcode == `SFSP_OP_RDCR)) begin
              O_SO_OE <= 1'b1;
              O_SO <= rd_shift[15];
              rd_shift <= {rd_shift[14:0], rd_shift[15]};
            end
          end
          default: ;
        endcase
      end
      O_BUSY <= busy;
      O_STATUS <= status;
      O_CONFIG <= config_r;
    end
  end
endmodule

/* verification/sfsp_top_props.sv */
// Checker for the flash status and protection block, bound to its top.
// Assumes one clock domain and that I_RESET_N stands for a power cycle.
`timescale 1ns/1ps
module sfsp_top_props (
  input wire I_CLK_SYS,
  input wire I_RESET_N,
  input wire I_WP_N,
  input wire O_BUSY,
  input wire O_ERASE_REQ,
  input wire O_PROG_REQ,
  input wire O_DUAL_PAGE_WIPE,
  input wire [23:0] O_OP_LEN,
  input wire O_DEEP_SLEEP,
  input wire [15:0] O_STATUS,
  input wire [7:0] O_CONFIG
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  logic [7:0] busy_cnt;
  // Counts the busy run so the array time is checked to the cycle
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N)
      busy_cnt <= 8'h00;
    else if (O_BUSY)
      busy_cnt <= busy_cnt + 8'h01;
    else
      busy_cnt <= 8'h00;
  end
  busy_time_a: assert property (
    $fell(O_BUSY) && !O_STATUS[15] && !O_STATUS[10] |-> busy_cnt == 8'h40)
    else $error("busy run is not 64 cycles");
  lock_bits_a: assert property (
    (O_STATUS[13:11] & $past(O_STATUS[13:11])) == $past(O_STATUS[13:11]))
    else $error("security lock bit cleared");
  frozen_a: assert property (
    O_STATUS[8] |=> $stable({O_STATUS[14:11], O_STATUS[9:2]}))
    else $error("status changed while locked down");
  hw_lock_a: assert property (
    O_STATUS[7] && !O_STATUS[8] && !O_STATUS[9] && !I_WP_N |=> $stable(O_STATUS[8:2]))
    else $error("status changed under pin lock");
  wake_wel_a: assert property ($rose(O_STATUS[1]) |-> !O_DEEP_SLEEP)
    else $error("write latch set in deep sleep");
  req_busy_a: assert property (
    O_PROG_REQ || O_ERASE_REQ |-> ##[0:3] O_BUSY)
    else $error("operation started without busy");
  req_wel_a: assert property (
    O_PROG_REQ || O_ERASE_REQ |-> O_STATUS[1] || $past(O_STATUS[1])
      || $past(O_STATUS[1], 2))
    else $error("operation started with latch clear");
  dp_wipe_a: assert property (
    O_ERASE_REQ && O_DUAL_PAGE_WIPE |-> O_CONFIG[7] ##[0:1] O_OP_LEN == 24'h000200)
    else $error("dual page wipe span wrong");
  reset_clear_a: assert property (
    $rose(I_RESET_N) |-> O_STATUS == 16'h0000 && !O_BUSY && !O_DEEP_SLEEP)
    else $error("state not cleared by power cycle");
endmodule

bind sfsp_top sfsp_top_props sfsp_top_props_i (.I_CLK_SYS(I_CLK_SYS),
  .I_RESET_N(I_RESET_N), .I_WP_N(I_WP_N), .O_BUSY(O_BUSY), .O_ERASE_REQ(O_ERASE_REQ),
  .O_PROG_REQ(O_PROG_REQ), .O_DUAL_PAGE_WIPE(O_DUAL_PAGE_WIPE), .O_OP_LEN(O_OP_LEN),
  .O_DEEP_SLEEP(O_DEEP_SLEEP), .O_STATUS(O_STATUS), .O_CONFIG(O_CONFIG));

/* verification/sfsp_host_model.sv */
// Host serial controller model that frames commands, mode 0.
// Assumes one caller at a time and a system clock of 25 ns.
`timescale 1ns/1ps
module sfsp_host_model (
  input wire i_clk,
  input wire i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  // Sends nb bits, MSB first; whole bytes unless a caller asks otherwise
  // Clock halts low between frames; SI flips when deselected so a stale bit
  // is never read as held data. Last 16 bits read back land in rd.
  task automatic xfer(input logic [39:0] d, input int nb, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (i = 0; i < nb; i++) begin
      o_si <= d[39 - i];
      repeat (4) @(posedge i_clk);
      rd = {rd[14:0], i_so};
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    repeat (12) @(posedge i_clk);
  endtask
endmodule

/* verification/sfsp_top_tb.sv */
// Self-checking bench for the flash status and protection block.
// Assumes the host model frames commands; the array side is only observed.
`timescale 1ns/1ps
`include "sfsp_defines.vh"
module sfsp_top_tb;
  logic clk, rst_n, wp_n;
  wire cs_n, sclk, si, so, busy, ereq, preq, dpw, sleep, pins;
  wire [15:0] st;
  wire [7:0] cfg;
  logic [15:0] rd;
  int mismatches, n_compared, cycles, n_prog, n_erase;
  sfsp_top sfsp_top_i (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
    .I_SI(si), .I_WP_N(wp_n), .I_PAUSE_N(1'b1), .O_SO(so), .O_SO_OE(),
    .O_PINS_ARE_DATA(pins), .O_PAUSE_ACTIVE(), .O_BUSY(busy), .O_ERASE_REQ(ereq),
    .O_PROG_REQ(preq), .O_DUAL_PAGE_WIPE(dpw), .O_OP_ADDR(), .O_OP_LEN(),
    .O_LOAD_OFFSET(), .O_LOAD_STROBE(), .O_LOAD_DATA(), .O_DEEP_SLEEP(sleep),
    .O_STATUS(st), .O_CONFIG(cfg));
  sfsp_host_model sfsp_host_model_i (.i_clk(clk), .i_so(so), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_si(si));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 8000 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (preq === 1'b1) n_prog <= n_prog + 1;
    if (ereq === 1'b1) n_erase <= n_erase + 1;
    if (cycles == 50000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [39:0] d, input int nb);
    int k;
    sfsp_host_model_i.xfer(d, nb, rd);
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
    chk("idle", 16'(busy), 16'h0000);
  endtask
  task automatic wcmd(input logic [39:0] d, input int nb);
    send({`SFSP_OP_WRITE_UNLOCK_CMD, 32'h0}, 8);
    send(d, nb);
  endtask
  task automatic status_write_cmd(input logic [7:0] lo, input logic [7:0] hi);
    wcmd({`SFSP_OP_STATUS_WRITE_CMD, lo, hi, 16'h0}, 24);
  endtask
  task automatic t_reset();
    chk("status", st, 16'h0000);
    chk("config", 16'(cfg), 16'h0000);
    chk("sleep", 16'(sleep), 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_latch();
    send({`SFSP_OP_STATUS_WRITE_CMD, 8'h04, 24'h0}, 16);
    chk("no latch", st, 16'h0000);
    send({`SFSP_OP_WRITE_UNLOCK_CMD, 32'h0}, 9);
    chk("odd length", st, 16'h0000);
    send({`SFSP_OP_WRITE_UNLOCK_CMD, 32'h0}, 8);
    chk("latch", st, 16'h0002);
    sfsp_host_model_i.xfer({`SFSP_OP_STATUS_WRITE_CMD, 8'h04, 24'h0}, 24, rd);
    chk("busy", 16'(busy), 16'h0001);
    send({`SFSP_OP_RDSR, 32'h0}, 24);
    chk("written", st, 16'h0004);
    chk("read back", rd, 16'h0004);
    $display("test latch done");
  endtask
  task automatic t_protect();
    logic [7:0] ops [4] = '{`SFSP_OP_PP, `SFSP_OP_PE, `SFSP_OP_SE, `SFSP_OP_BE};
    int j, p, e;
    p = n_prog;
    e = n_erase;
    for (j = 0; j < 4; j++) begin
      wcmd({ops[j], 24'h0F8000, 8'hA5}, j == 0 ? 40 : 32);
      chk("refused latch", st, 16'h0004);
    end
    chk("guarded", 16'(n_prog + n_erase - p - e), 16'h0000);
    wcmd({`SFSP_OP_CE, 32'h0}, 8);
    chk("chip guarded", 16'(n_erase - e), 16'h0000);
    status_write_cmd(8'h04, 8'h40);
    wcmd({`SFSP_OP_PP, 24'h000000, 8'h5A}, 40);
    chk("inverted low", 16'(n_prog - p), 16'h0000);
    wcmd({`SFSP_OP_PP, 24'h0F0000, 8'h5A}, 40);
    chk("inverted high", 16'(n_prog - p), 16'h0001);
    status_write_cmd(8'h00, 8'h00);
    wcmd({`SFSP_OP_CE, 32'h0}, 8);
    chk("chip erase", 16'(n_erase - e), 16'h0001);
    $display("test protect done");
  endtask
  task automatic t_srp();
    status_write_cmd(8'h80, 8'h00);
    wp_n <= 1'b0;
    status_write_cmd(8'h84, 8'h00);
    chk("pin lock", st, 16'h0080);
    wp_n <= 1'b1;
    status_write_cmd(8'h84, 8'h00);
    chk("pin open", st, 16'h0084);
    status_write_cmd(8'h80, 8'h0A);
    chk("quad and lock", st, 16'h0A80);
    chk("pins", 16'(pins), 16'h0001);
    status_write_cmd(8'h80, 8'h00);
    chk("lock kept", st, 16'h0880);
    $display("test guard done");
  endtask
  task automatic t_cfg();
    wcmd({`SFSP_OP_WRCR, 8'h80, 24'h0}, 16);
    chk("config", 16'(cfg), 16'h0080);
    wcmd({`SFSP_OP_PE, 24'h000200, 8'h00}, 32);
    chk("dual wipe", 16'(dpw), 16'h0001);
    $display("test config done");
  endtask
  task automatic t_sleep();
    send({`SFSP_OP_DPD, 32'h0}, 8);
    chk("asleep", 16'(sleep), 16'h0001);
    send({`SFSP_OP_WRITE_UNLOCK_CMD, 32'h0}, 8);
    chk("ignored", st, 16'h0880);
    send({`SFSP_OP_RDPD, 32'h0}, 8);
    chk("awake", 16'(sleep), 16'h0000);
    $display("test sleep done");
  endtask
  task automatic t_power();
    status_write_cmd(8'h00, 8'h01);
    chk("lockdown", st, 16'h0900);
    status_write_cmd(8'h04, 8'h00);
    chk("frozen", st, 16'h0900);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("guard cleared", 16'(st[8:7]), 16'h0000);
    status_write_cmd(8'h04, 8'h00);
    chk("writable", 16'(st[8:2]), 16'h0001);
    $display("test power done");
  endtask
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    n_prog = 0;
    n_erase = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_latch();
    t_protect();
    t_srp();
    t_cfg();
    t_sleep();
    t_power();
    conclude();
  end
endmodule
